// [sram_cfg.svh]
// constants for the synchronous burst static ram: widths, depths, resets
// assumes inclusion by the package and design files of this block only
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH

`define ADDR_W 15
`define DATA_W 9
`define BURST_W 2
`define MEM_DEPTH 32768
`define BUF_DEPTH 2
`define BUF_IDX_W 1
`define BUF_CNT_W 2
`define RST_PIN_HIGH 1'b1
`define RST_PIN_LOW 1'b0
`define RST_ADDR 15'h0000
`define RST_DATA 9'h000
`define RST_BURST 2'h0
// idle pins: write, enable, strobes, advance high; chip deselected
`define RST_CTL 7'h6F

`endif

// [sram_pkg.sv]
// types shared by the burst static ram and its read buffer
// assumes sram_cfg.svh on the include path
`include "sram_cfg.svh"

package sram_pkg;
	typedef logic [`ADDR_W-1:0] word_addr_t;
	typedef logic [`DATA_W-1:0] word_data_t;
	typedef logic [`BURST_W-1:0] burst_cnt_t;
	// gray codes along deselected -> access -> wait
	typedef enum logic [1:0] {
		ST_DESEL = 2'h0,
		ST_ACCESS = 2'h1,
		ST_WAIT = 2'h3
	} state_t;
	typedef enum logic [1:0] {
		ACC_NONE = 2'h0,
		ACC_READ = 2'h1,
		ACC_WRITE = 2'h2
	} access_t;
endpackage : sram_pkg

// [read_buffer.sv]
// two-entry buffer for read words between the array and the pin register
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "sram_cfg.svh"

module read_buffer (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// fill side
	input wire logic fill_valid_in,
	input wire sram_pkg::word_data_t fill_data_in,
	output logic fill_ready_out,
	// drain side
	output logic drain_valid_out,
	output sram_pkg::word_data_t drain_data_out,
	input wire logic drain_ready_in
);
	import sram_pkg::*;

	word_data_t slot [0:`BUF_DEPTH-1];
	logic [`BUF_IDX_W-1:0] rd_idx;
	logic [`BUF_IDX_W-1:0] wr_idx;
	logic [`BUF_CNT_W-1:0] count;
	logic [`BUF_IDX_W-1:0] next_rd_idx;
	logic [`BUF_IDX_W-1:0] next_wr_idx;
	logic [`BUF_CNT_W-1:0] next_count;
	logic push;
	logic pop;

	always_comb begin
		fill_ready_out = (count != `BUF_CNT_W'(`BUF_DEPTH));
		drain_valid_out = (count != `BUF_CNT_W'(0));
		drain_data_out = slot[rd_idx];
		push = fill_valid_in & fill_ready_out;
		pop = drain_valid_out & drain_ready_in;
		next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
		next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
		next_count = count + `BUF_CNT_W'(push) - `BUF_CNT_W'(pop);
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_idx <= '0;
			wr_idx <= '0;
			count <= '0;
		end else begin
			rd_idx <= next_rd_idx;
			wr_idx <= next_wr_idx;
			count <= next_count;
		end
	end

	// storage has no reset; count guards every read of it
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			slot[wr_idx] <= fill_data_in;
		end
	end
endmodule : read_buffer

// [sync_burst_sram.sv]
// synchronous burst static ram, 32768 words of 9 bits, with burst counter
// assumes pins arrive asynchronously; the data pins are resolved outside
`timescale 1ns/1ps
`include "sram_cfg.svh"

module sync_burst_sram (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// address and data pins
	input wire sram_pkg::word_addr_t word_address_in,
	input wire sram_pkg::word_data_t data_pins_in,
	output sram_pkg::word_data_t data_pins_out,
	output logic data_pins_oe_out,
	// control pins
	input wire logic write_n_in,
	input wire logic out_enable_n_in,
	input wire logic select_high_in,
	input wire logic select_low_n_in,
	input wire logic proc_start_n_in,
	input wire logic ctrl_start_n_in,
	input wire logic burst_advance_n_in
);
	import sram_pkg::*;

	// two-stage pin synchronisers; stage two is the input register
	word_addr_t addr_s1, addr_q, next_addr_s1, next_addr_q;
	word_data_t data_s1, data_q, next_data_s1, next_data_q;
	logic [6:0] ctl_s1, ctl_q, next_ctl_s1, next_ctl_q;
	logic q_write_n, q_oe_n, q_sel_hi, q_sel_lo_n;
	logic q_proc_n, q_ctrl_n, q_adv_n;

	always_comb begin
		next_addr_s1 = word_address_in;
		next_data_s1 = data_pins_in;
		next_ctl_s1 = {write_n_in, out_enable_n_in, select_high_in,
			select_low_n_in, proc_start_n_in, ctrl_start_n_in,
			burst_advance_n_in};
		next_addr_q = addr_s1;
		next_data_q = data_s1;
		next_ctl_q = ctl_s1;
		{q_write_n, q_oe_n, q_sel_hi, q_sel_lo_n, q_proc_n, q_ctrl_n,
			q_adv_n} = ctl_q;
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			addr_s1 <= `RST_ADDR;
			addr_q <= `RST_ADDR;
			data_s1 <= `RST_DATA;
			data_q <= `RST_DATA;
			// idle levels, so no start is seen while the stages refill
			ctl_s1 <= `RST_CTL;
			ctl_q <= `RST_CTL;
		end else begin
			addr_s1 <= next_addr_s1;
			addr_q <= next_addr_q;
			data_s1 <= next_data_s1;
			data_q <= next_data_q;
			ctl_s1 <= next_ctl_s1;
			ctl_q <= next_ctl_q;
		end
	end

	// burst sequencing
	state_t state, next_state;
	word_addr_t base, next_base;
	burst_cnt_t cnt, next_cnt;
	access_t acc;
	word_addr_t acc_addr;
	logic selected, proc_start, ctrl_start, load, buf_ready;

	always_comb begin
		selected = q_sel_hi & ~q_sel_lo_n;
		proc_start = ~q_proc_n;
		ctrl_start = ~q_ctrl_n & q_proc_n;
		load = proc_start | ctrl_start;
		next_state = state;
		next_base = base;
		next_cnt = cnt;
		acc = ACC_NONE;
		if (load) begin
			// selects matter only here
			if (selected) begin
				next_base = addr_q;
				next_cnt = addr_q[`BURST_W-1:0];
				next_state = ST_ACCESS;
				if (proc_start || q_write_n) begin
					acc = ACC_READ;
				end else begin
					acc = ACC_WRITE;
				end
			end else begin
				next_state = ST_DESEL;
			end
		end else if (state != ST_DESEL) begin
			acc = q_write_n ? ACC_READ : ACC_WRITE;
			// a full read buffer stalls a continued read like a wait state, so a
			// receiver holding output enable high loses no burst word after the start
			if (q_write_n && !buf_ready) begin
				acc = ACC_NONE;
				next_state = ST_WAIT;
			end else if (!q_adv_n) begin
				next_cnt = cnt + 1'b1;
				next_state = ST_ACCESS;
			end else begin
				next_state = ST_WAIT;
			end
		end
		// increment lands before the access; upper bits never move
		acc_addr = {next_base[`ADDR_W-1:`BURST_W], next_cnt};
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state <= ST_DESEL;
			base <= `RST_ADDR;
			cnt <= `RST_BURST;
		end else begin
			state <= next_state;
			base <= next_base;
			cnt <= next_cnt;
		end
	end

	// array: write completes at the access edge with no external pulse
	word_data_t mem [0:`MEM_DEPTH-1];

	always_ff @(posedge clk_sys_in) begin
		if (acc == ACC_WRITE) begin
			mem[acc_addr] <= data_q;
		end
	end

	// read words queue while output enable is high
	// limitation: a start cannot stall, its read into a full buffer is lost
	logic drain_valid, drain_ready;
	word_data_t drain_data;

	read_buffer read_buf (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.fill_valid_in(acc == ACC_READ),
		.fill_data_in(mem[acc_addr]),
		.fill_ready_out(buf_ready),
		.drain_valid_out(drain_valid),
		.drain_data_out(drain_data),
		.drain_ready_in(drain_ready)
	);

	// pin driver register
	word_data_t dout, next_dout;
	logic dout_oe, next_dout_oe;

	always_comb begin
		drain_ready = ~q_oe_n & (acc != ACC_WRITE) & (state != ST_DESEL);
		next_dout = dout;
		next_dout_oe = drain_valid & drain_ready;
		if (next_dout_oe) begin
			next_dout = drain_data;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			dout <= `RST_DATA;
			dout_oe <= `RST_PIN_LOW;
		end else begin
			dout <= next_dout;
			dout_oe <= next_dout_oe;
		end
	end

	assign data_pins_out = dout;
	assign data_pins_oe_out = dout_oe;

	// checks
	desel_state_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		load && !selected |=> state == ST_DESEL)
		else $error("unselected start did not deselect");

	proc_read_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		proc_start && selected |-> acc == ACC_READ)
		else $error("processor start did not read");

	ctrl_write_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		ctrl_start && selected && !q_write_n |-> acc == ACC_WRITE)
		else $error("controller start with write low did not write");

	ctrl_read_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		ctrl_start && selected && q_write_n |-> acc == ACC_READ)
		else $error("controller start with write high did not read");

	base_load_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		load && selected |=> base == $past(addr_q)
		&& cnt == $past(addr_q[1:0]))
		else $error("base address not loaded");

	upper_addr_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && acc != ACC_NONE
		|-> acc_addr[`ADDR_W-1:`BURST_W] == base[`ADDR_W-1:`BURST_W])
		else $error("burst changed the upper address bits");

	burst_step_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && state != ST_DESEL && !q_adv_n && acc != ACC_NONE
		|=> cnt == $past(cnt) + 2'h1)
		else $error("burst address did not advance");

	cont_write_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && state != ST_DESEL && !q_adv_n && !q_write_n
		|-> acc == ACC_WRITE && acc_addr[1:0] == cnt + 2'h1)
		else $error("continued write not at next address");

	cont_read_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && state != ST_DESEL && !q_adv_n
		&& q_write_n && buf_ready
		|-> acc == ACC_READ && acc_addr[1:0] == cnt + 2'h1)
		else $error("continued read not at next address");

	suspend_acc_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && state != ST_DESEL && q_adv_n
		&& (buf_ready || !q_write_n)
		|-> acc_addr[1:0] == cnt && acc != ACC_NONE)
		else $error("suspended burst missed the current address");

	wait_hold_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && q_adv_n |=> cnt == $past(cnt)
		&& base == $past(base))
		else $error("wait state moved the burst address");

	stall_hold_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load && state != ST_DESEL && !q_adv_n
		&& q_write_n && !buf_ready
		|=> cnt == $past(cnt) && state == ST_WAIT)
		else $error("refused read moved the burst address");

	upper_fixed_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		!load |=> base == $past(base) && state != ST_DESEL
		|| $past(state) == ST_DESEL)
		else $error("burst changed base or selection");

	desel_none_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(load && !selected) || (!load && state == ST_DESEL)
		|-> acc == ACC_NONE)
		else $error("deselected device made an access");

	burst_wrap_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		(!load && state != ST_DESEL && !q_adv_n && q_write_n == 1'b0)[*4]
		|=> cnt == $past(cnt, 4))
		else $error("burst did not wrap to start");

	oe_float_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		q_oe_n |=> !data_pins_oe_out)
		else $error("pins driven with output enable high");

	pins_drive_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		drain_valid && drain_ready
		|=> data_pins_oe_out && data_pins_out == $past(drain_data))
		else $error("drained word not driven on the pins");

	write_hiz_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		acc == ACC_WRITE || state == ST_DESEL |=> !data_pins_oe_out)
		else $error("pins driven during write or deselect");

	write_store_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		acc == ACC_WRITE |=> mem[$past(acc_addr)] == $past(data_q))
		else $error("write data not stored");

	read_out_a: assert property (
		@(posedge clk_sys_in) disable iff (rst_in)
		acc == ACC_READ && !drain_valid && drain_ready && buf_ready
		|=> drain_valid ##1 (data_pins_oe_out || !$past(drain_ready)))
		else $error("read data late");

	burst_four_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		load && selected ##1 (!load && !q_adv_n)[*3]);
	suspend_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		state == ST_ACCESS ##1 state == ST_WAIT ##1 state == ST_ACCESS);
	ctrl_write_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		ctrl_start && selected && !q_write_n);
	buf_full_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		!buf_ready);
endmodule : sync_burst_sram

// [bus_master.sv]
// bus master model: drives the memory pins, one pin pattern per call
// assumes drive is called just after a falling clock edge
`timescale 1ns/1ps

module bus_master (
	// clock
	input wire logic clk_sys_in,
	// memory data side
	input wire sram_pkg::word_data_t q_in,
	input wire logic q_oe_in,
	output sram_pkg::word_data_t d_out,
	// memory control side
	output logic wr_n_out,
	output logic oe_n_out,
	output logic sel_hi_out,
	output logic sel_lo_n_out,
	output logic ps_n_out,
	output logic cs_n_out,
	output logic adv_n_out,
	output sram_pkg::word_addr_t addr_out
);
	import sram_pkg::*;
	word_data_t wdata = 9'h000;
	word_data_t last = 9'h000;
	// released bus shows the inverse of its last level, never a held value
	assign d_out = q_oe_in ? q_in : (!wr_n_out ? wdata : ~last);
	always @(posedge clk_sys_in) begin
		last <= d_out;
	end
	initial begin
		{ps_n_out, cs_n_out, adv_n_out, wr_n_out} = 4'hF;
		{oe_n_out, sel_hi_out, sel_lo_n_out} = 3'h5;
		addr_out = 15'h0000;
	end
	// c = start_p, start_c, advance, write, out_en, sel_hi, sel_lo (all _n but sel_hi)
	task automatic drive(input logic [6:0] c, input word_addr_t a,
		input word_data_t d);
		{ps_n_out, cs_n_out, adv_n_out, wr_n_out} = c[6:3];
		// a write always comes with output enable high
		oe_n_out = c[2] | ~c[3];
		{sel_hi_out, sel_lo_n_out} = c[1:0];
		addr_out = a;
		wdata = d;
	endtask : drive
endmodule : bus_master

// [sync_burst_sram_32kx9_tb.sv]
// bench for the burst static ram: table of pin cycles, then hand cases
// assumes bus_master as the far side and a reference model kept here
`timescale 1ns/1ps

module sync_burst_sram_32kx9_tb;
	import sram_pkg::*;
	typedef struct {logic [6:0] c; word_addr_t a; word_data_t d;} row_t;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	word_data_t dq, q;
	word_addr_t addr, pa;
	logic oe, wr_n, oe_n, s_hi, s_lo_n, ps_n, cs_n, adv_n;
	logic live = 1'b0;
	logic hold_off = 1'b0;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	word_data_t mem [word_addr_t];
	word_data_t exp_q [$];
	row_t rows [22] = '{
		'{7'h56, 15'h7FFF, 9'h1A5},
		'{7'h66, 15'h0000, 9'h05A},
		'{7'h66, 15'h0000, 9'h133},
		'{7'h76, 15'h0000, 9'h0F0},
		'{7'h66, 15'h0000, 9'h0CC},
		'{7'h66, 15'h0000, 9'h155},
		'{7'h66, 15'h0000, 9'h0AA},
		'{7'h66, 15'h0000, 9'h1E1},
		'{7'h3C, 15'h0000, 9'h000},
		'{7'h56, 15'h0010, 9'h111},
		'{7'h3C, 15'h0000, 9'h000},
		'{7'h57, 15'h0010, 9'h0EE},
		'{7'h66, 15'h0000, 9'h0EE},
		'{7'h1A, 15'h7FFF, 9'h000},
		'{7'h6A, 15'h0000, 9'h000},
		'{7'h68, 15'h0000, 9'h000},
		'{7'h7A, 15'h0000, 9'h000},
		'{7'h6A, 15'h0000, 9'h000},
		'{7'h6A, 15'h0000, 9'h000},
		'{7'h38, 15'h0000, 9'h000},
		'{7'h5A, 15'h0010, 9'h000},
		'{7'h38, 15'h0000, 9'h000}
	};

	always #25 clk_sys_in = ~clk_sys_in;

	sync_burst_sram sync_burst_sram_inst (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .word_address_in(pa), .data_pins_in(dq),
		.data_pins_out(q), .data_pins_oe_out(oe), .write_n_in(wr_n),
		.out_enable_n_in(oe_n), .select_high_in(s_hi),
		.select_low_n_in(s_lo_n), .proc_start_n_in(ps_n),
		.ctrl_start_n_in(cs_n), .burst_advance_n_in(adv_n));

	bus_master bus_master_inst (.clk_sys_in(clk_sys_in), .q_in(q),
		.q_oe_in(oe), .d_out(dq), .wr_n_out(wr_n), .oe_n_out(oe_n),
		.sel_hi_out(s_hi), .sel_lo_n_out(s_lo_n), .ps_n_out(ps_n),
		.cs_n_out(cs_n), .adv_n_out(adv_n), .addr_out(pa));

	task automatic check_word(input string what, input word_data_t e,
		input word_data_t g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : check_word

	task automatic check_bit(input string what, input logic e,
		input logic g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask : check_bit

	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	// reference model: a start loads, a continuation steps the low bits
	task automatic apply(input row_t r);
		logic wr;
		wr = r.c[3];
		if (!r.c[6] || !r.c[5]) begin
			live = r.c[1] & !r.c[0];
			addr = r.a;
			if (!r.c[6]) wr = 1'b1;
		end else if (!r.c[4]) begin
			addr[1:0] = addr[1:0] + 2'h1;
		end
		if (live && !wr) mem[addr] = r.d;
		if (live && wr) exp_q.push_back(mem[addr]);
		bus_master_inst.drive(r.c, r.a, r.d);
		@(negedge clk_sys_in);
	endtask : apply

	task automatic wait_drain(input string name);
		for (int i = 0; i < 20 && exp_q.size() != 0; i++)
			@(negedge clk_sys_in);
		check_word("words left", 9'h000, word_data_t'(exp_q.size()));
		$display("test %s done", name);
	endtask : wait_drain

	always @(negedge clk_sys_in) begin
		if (!rst_in && oe === 1'b1) begin
			if (hold_off || exp_q.size() == 0)
				check_bit("pins driven", 1'b0, oe);
			else
				check_word("read data", exp_q.pop_front(), q);
		end
	end

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			results();
		end
	end

	initial begin
		repeat (4) @(negedge clk_sys_in);
		rst_in = 1'b0;
		check_bit("oe after reset", 1'b0, oe);
		check_word("data after reset", 9'h000, q);
		$display("test reset done");
		foreach (rows[i])
			apply(rows[i]);
		wait_drain("table");
		apply('{7'h56, 15'h0123, 9'h0B4});
		apply('{7'h1A, 15'h0123, 9'h000});
		apply('{7'h38, 15'h0000, 9'h000});
		wait_drain("write then read");
		hold_off = 1'b1;
		apply('{7'h1E, 15'h7FFC, 9'h000});
		apply('{7'h3C, 15'h0000, 9'h000});
		repeat (6) @(negedge clk_sys_in);
		hold_off = 1'b0;
		apply('{7'h1A, 15'h7FFD, 9'h000});
		// the start drained nothing while deselected, so the buffer is full and the advance is stalled; the model stays put
		bus_master_inst.drive(7'h6A, 15'h0000, 9'h000);
		@(negedge clk_sys_in);
		apply('{7'h38, 15'h0000, 9'h000});
		wait_drain("held read");
		results();
	end
endmodule : sync_burst_sram_32kx9_tb
